// ### logic/tpp_cfg.svh
// Constants of the timer pair: register offsets, field positions,
// reset values and prescaler tap exponents.
// Assumes inclusion by bare name from the design files.
`ifndef TPP_CFG_SVH
`define TPP_CFG_SVH

`define TPP_ADDR_W 4
`define TPP_DATA_W 8

`define TPP_ADDR_CTRL0 4'h0
`define TPP_ADDR_CTRL1 4'h1
`define TPP_ADDR_PWM0 4'h2
`define TPP_ADDR_PWM1 4'h3
`define TPP_ADDR_TCMP_LO 4'h4
`define TPP_ADDR_TCMP_HI 4'h5
`define TPP_ADDR_CNT0 4'h6
`define TPP_ADDR_CNT1 4'h7
`define TPP_ADDR_CFG 4'h8

`define TPP_CTRL_TFF 7
`define TPP_CTRL_CS_MSB 6
`define TPP_CTRL_CS_LSB 4
`define TPP_CTRL_RUN 3
`define TPP_CTRL_MODE_MSB 2
`define TPP_CTRL_MODE_LSB 0

`define TPP_CFG_TAPSEL 0
`define TPP_CFG_FLOP0 1
`define TPP_CFG_FLOP1 2

`define TPP_CTRL_RST 8'h00
`define TPP_CMP_RST 8'h00
`define TPP_CNT_RST 8'h00
`define TPP_CNT_MAX 8'hFF
`define TPP_RDATA_IDLE 8'h00

`define TPP_TAP_SLOW 11
`define TPP_TAP_MID 7
`define TPP_TAP_FAST 5
`define TPP_TAP_FASTER 3
`define TPP_TAP_HALF 1
`define TPP_LF_DIV 3

`endif

// ### logic/tpp_pkg.sv
// Types of the timer pair: operating modes and source clock codes.
// Assumes tpp_cfg.svh supplies the numeric constants.
package tpp_pkg;

	typedef enum logic [2:0] {
		TPP_MODE_OFF = 3'b000,
		TPP_MODE_PWM8 = 3'b011,
		TPP_MODE_TMR16 = 3'b100
	} tpp_mode_t;

	typedef enum logic [2:0] {
		TPP_CS_SLOW = 3'b000,
		TPP_CS_MID = 3'b001,
		TPP_CS_FAST = 3'b010,
		TPP_CS_FASTER = 3'b011,
		TPP_CS_LF = 3'b100,
		TPP_CS_HALF = 3'b101,
		TPP_CS_FULL = 3'b110,
		TPP_CS_NONE = 3'b111
	} tpp_cs_t;

endpackage

// ### logic/tpp_prescaler.sv
// Prescaler of the timer pair: one-cycle enables for every source tap.
// Assumes a low-frequency clock pin asynchronous to the system clock.
`timescale 1ns/1ps
`include "tpp_cfg.svh"
module tpp_prescaler #(
	parameter int DIV_W = `TPP_TAP_SLOW
) (
	input wire logic clk, // System clock
	input wire logic rstn, // Async reset, active low
	input wire logic lf_clk_pin, // Low-frequency clock pin
	input wire logic tap_sel, // Slowest tap from LF clock when high
	output logic [7:0] ticks // Enables indexed by source code
);
	import tpp_pkg::*;

	generate
		if (DIV_W < `TPP_TAP_SLOW) begin : g_chk
			$error("tpp_prescaler: DIV_W too small");
		end
	endgenerate

	logic [DIV_W-1:0] div;
	logic [DIV_W-1:0] next_div;
	logic lf_s1, lf_s2, lf_s3;
	logic [`TPP_LF_DIV-1:0] lf_div;
	logic [`TPP_LF_DIV-1:0] next_lf_div;
	logic lf_edge;

	function automatic logic tap_hit(input logic [DIV_W-1:0] d,
		input int k);
		logic hit;
		hit = 1'b1;
		for (int b = 0; b < DIV_W; b++) begin
			if (b < k && !d[b])
				hit = 1'b0;
		end
		return hit;
	endfunction

	assign lf_edge = lf_s2 & ~lf_s3;

	always_comb begin
		next_div = div + 1'b1;
		next_lf_div = lf_edge ? lf_div + 1'b1 : lf_div;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			div <= '0;
			lf_div <= '0;
			lf_s1 <= 1'b0;
			lf_s2 <= 1'b0;
			lf_s3 <= 1'b0;
		end else begin
			div <= next_div;
			lf_div <= next_lf_div;
			lf_s1 <= lf_clk_pin;
			lf_s2 <= lf_s1;
			lf_s3 <= lf_s2;
		end
	end

	always_comb begin
		ticks = 8'h00;
		ticks[TPP_CS_SLOW] = tap_sel ? (lf_edge && (&lf_div)) :
			tap_hit(div, `TPP_TAP_SLOW);
		ticks[TPP_CS_MID] = tap_hit(div, `TPP_TAP_MID);
		ticks[TPP_CS_FAST] = tap_hit(div, `TPP_TAP_FAST);
		ticks[TPP_CS_FASTER] = tap_hit(div, `TPP_TAP_FASTER);
		ticks[TPP_CS_LF] = lf_edge;
		ticks[TPP_CS_HALF] = tap_hit(div, `TPP_TAP_HALF);
		ticks[TPP_CS_FULL] = 1'b1;
	end

endmodule

// ### logic/tpp_core.sv
// Timer pair: two 8-bit counters with PWM output, cascadable to a
// 16-bit interval timer.
// Assumes a single-cycle register port on SYS_CLK and an external
// low-frequency clock pin.
//
// Functional notes
// - PWM mode counts up on the chosen source tap, 8-bit resolution.
// - Counter equal to active compare flips output flop, keeps counting.
// - Overflow flips the flop again, clears counter, pulses match irq.
// - Flop starting level set by init bit; reset clears it.
// - PWM pin always drives inverse of output flop.
// - Compare writes while running wait in holding stage until irq.
// - While stopped, written compare value becomes active right away.
// - Compare register reads return the holding stage.
// - Stopping holds the pin at its level at that moment.
// - Control bit 3 runs the counter, bit 7 sets the flop.
// - PWM source selectable among prescaled taps and undivided clocks.
// - 16-bit mode cascades both counters into one up-counter.
// - Upper start bit runs it; match pulses upper irq and clears.
// - Timer compare is unbuffered, effective right after the write.
// - 16-bit source selectable among four prescaled taps.
`timescale 1ns/1ps
`include "tpp_cfg.svh"
module tpp_core #(
	parameter int DIV_W = `TPP_TAP_SLOW
) (
	input wire logic SYS_CLK, // System clock, 20 MHz
	input wire logic RSTN, // Async reset, active low
	input wire logic [`TPP_ADDR_W-1:0] ADDR, // Register address
	input wire logic [`TPP_DATA_W-1:0] WDATA, // Write data
	input wire logic WR, // Write strobe
	input wire logic RD, // Read strobe
	output logic [`TPP_DATA_W-1:0] RDATA, // Read data, cycle after RD
	input wire logic LF_CLK, // Low-frequency clock pin
	output logic [1:0] PWM_OUT_PIN, // PWM pins, one per counter
	output logic [1:0] TIMER_MATCH_IRQ // Match pulses, one per counter
);
	import tpp_pkg::*;

	generate
		if (DIV_W < `TPP_TAP_SLOW) begin : g_chk
			$error("tpp_core: DIV_W too small");
		end
	endgenerate

	// Register state
	logic [7:0] ctrl [0:1];
	logic [7:0] next_ctrl [0:1];
	logic [7:0] pwm_hold [0:1];
	logic [7:0] next_pwm_hold [0:1];
	logic [7:0] tcmp_lo, tcmp_hi;
	logic [7:0] next_tcmp_lo, next_tcmp_hi;
	logic tap_sel, next_tap_sel;
	logic [7:0] rdata_q, next_rdata;

	// Counter state
	logic [7:0] cnt [0:1];
	logic [7:0] next_cnt [0:1];
	logic [7:0] pwm_act [0:1];
	logic [7:0] next_pwm_act [0:1];
	logic [1:0] flop, next_flop;
	logic [1:0] irq, next_irq;

	logic [7:0] ticks;
	logic [1:0] src_tick;
	logic [1:0] is_pwm;
	logic [1:0] running;
	logic mode16;
	logic tick16;
	logic [15:0] cnt16;
	logic [15:0] cnt16_inc;
	logic [15:0] cmp16;

	tpp_prescaler #(
		.DIV_W(DIV_W)
	) u_presc (
		.clk(SYS_CLK),
		.rstn(RSTN),
		.lf_clk_pin(LF_CLK),
		.tap_sel(tap_sel),
		.ticks(ticks)
	);

	function automatic tpp_mode_t mode_of(input logic [7:0] c);
		tpp_mode_t m;
		m = TPP_MODE_OFF;
		if (c[`TPP_CTRL_MODE_MSB:`TPP_CTRL_MODE_LSB] == TPP_MODE_PWM8)
			m = TPP_MODE_PWM8;
		else if (c[`TPP_CTRL_MODE_MSB:`TPP_CTRL_MODE_LSB] ==
			TPP_MODE_TMR16)
			m = TPP_MODE_TMR16;
		return m;
	endfunction

	function automatic logic [2:0] cs_of(input logic [7:0] c);
		return c[`TPP_CTRL_CS_MSB:`TPP_CTRL_CS_LSB];
	endfunction

	function automatic logic wr_hit(input logic w,
		input logic [`TPP_ADDR_W-1:0] a,
		input logic [`TPP_ADDR_W-1:0] target);
		return w && (a == target);
	endfunction

	// Mode and source decoding
	assign mode16 = (mode_of(ctrl[1]) == TPP_MODE_TMR16);
	assign cnt16 = {cnt[1], cnt[0]};
	assign cnt16_inc = cnt16 + 16'h0001;
	assign cmp16 = {tcmp_hi, tcmp_lo};
	// Only the four slowest prescaled taps, codes 0 to 3, serve 16-bit mode
	assign tick16 = (cs_of(ctrl[0]) <= TPP_CS_FASTER) &&
		ticks[cs_of(ctrl[0])];

	generate
		for (genvar g = 0; g < 2; g++) begin : g_src
			assign src_tick[g] = ticks[cs_of(ctrl[g])];
			assign is_pwm[g] = !mode16 &&
				(mode_of(ctrl[g]) == TPP_MODE_PWM8);
			assign running[g] = ctrl[g][`TPP_CTRL_RUN];
		end
	endgenerate

	// Register writes
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			next_ctrl[i] = ctrl[i];
			next_pwm_hold[i] = pwm_hold[i];
		end
		next_tcmp_lo = tcmp_lo;
		next_tcmp_hi = tcmp_hi;
		next_tap_sel = tap_sel;
		if (wr_hit(WR, ADDR, `TPP_ADDR_CTRL0)) begin
			next_ctrl[0] = WDATA;
		end else if (wr_hit(WR, ADDR, `TPP_ADDR_CTRL1)) begin
			next_ctrl[1] = WDATA;
		end else if (wr_hit(WR, ADDR, `TPP_ADDR_PWM0)) begin
			next_pwm_hold[0] = WDATA;
		end else if (wr_hit(WR, ADDR, `TPP_ADDR_PWM1)) begin
			next_pwm_hold[1] = WDATA;
		end else if (wr_hit(WR, ADDR, `TPP_ADDR_TCMP_LO)) begin
			next_tcmp_lo = WDATA;
		end else if (wr_hit(WR, ADDR, `TPP_ADDR_TCMP_HI)) begin
			next_tcmp_hi = WDATA;
		end else if (wr_hit(WR, ADDR, `TPP_ADDR_CFG)) begin
			next_tap_sel = WDATA[`TPP_CFG_TAPSEL];
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			for (int i = 0; i < 2; i++) begin
				ctrl[i] <= `TPP_CTRL_RST;
				pwm_hold[i] <= `TPP_CMP_RST;
			end
			tcmp_lo <= `TPP_CMP_RST;
			tcmp_hi <= `TPP_CMP_RST;
			tap_sel <= 1'b0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				ctrl[i] <= next_ctrl[i];
				pwm_hold[i] <= next_pwm_hold[i];
			end
			tcmp_lo <= next_tcmp_lo;
			tcmp_hi <= next_tcmp_hi;
			tap_sel <= next_tap_sel;
		end
	end

	// Counters, output flops and match pulses
	always_comb begin
		logic ctrl_wr;
		logic toggle;
		ctrl_wr = 1'b0;
		toggle = 1'b0;
		for (int i = 0; i < 2; i++) begin
			next_cnt[i] = cnt[i];
			next_pwm_act[i] = pwm_act[i];
		end
		next_flop = flop;
		next_irq = 2'b00;

		for (int i = 0; i < 2; i++) begin
			ctrl_wr = wr_hit(WR, ADDR, i[`TPP_ADDR_W-1:0]);
			toggle = 1'b0;
			if (!running[i]) begin
				// Stopped: compare follows holding stage
				next_pwm_act[i] = pwm_hold[i];
				if (!mode16 || i == 1)
					next_cnt[i] = `TPP_CNT_RST;
				// Flop is loaded only by a write that finds
				// the counter already stopped and keeps it so
				if (ctrl_wr && !WDATA[`TPP_CTRL_RUN])
					next_flop[i] = WDATA[`TPP_CTRL_TFF];
			end else if (is_pwm[i] && src_tick[i]) begin
				if (cnt[i] == `TPP_CNT_MAX) begin
					next_cnt[i] = `TPP_CNT_RST;
					toggle = 1'b1;
					next_irq[i] = 1'b1;
					next_pwm_act[i] = pwm_hold[i];
				end else begin
					next_cnt[i] = cnt[i] + 8'h01;
					if (cnt[i] + 8'h01 == pwm_act[i])
						toggle = 1'b1;
				end
				next_flop[i] = flop[i] ^ toggle;
			end
		end

		// Cascaded 16-bit timer
		if (mode16) begin
			if (!running[1]) begin
				next_cnt[0] = `TPP_CNT_RST;
				next_cnt[1] = `TPP_CNT_RST;
			end else if (tick16) begin
				if (cnt16_inc == cmp16) begin
					next_cnt[0] = `TPP_CNT_RST;
					next_cnt[1] = `TPP_CNT_RST;
					next_irq[1] = 1'b1;
				end else begin
					next_cnt[0] = cnt[0] + 8'h01;
					if (cnt[0] == `TPP_CNT_MAX)
						next_cnt[1] = cnt[1] + 8'h01;
				end
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			for (int i = 0; i < 2; i++) begin
				cnt[i] <= `TPP_CNT_RST;
				pwm_act[i] <= `TPP_CMP_RST;
			end
			flop <= 2'b00;
			irq <= 2'b00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				cnt[i] <= next_cnt[i];
				pwm_act[i] <= next_pwm_act[i];
			end
			flop <= next_flop;
			irq <= next_irq;
		end
	end

	// Read port: data stand only in the cycle after the strobe
	always_comb begin
		next_rdata = `TPP_RDATA_IDLE;
		if (RD) begin
			if (ADDR == `TPP_ADDR_CTRL0) begin
				next_rdata = ctrl[0];
			end else if (ADDR == `TPP_ADDR_CTRL1) begin
				next_rdata = ctrl[1];
			end else if (ADDR == `TPP_ADDR_PWM0) begin
				next_rdata = pwm_hold[0];
			end else if (ADDR == `TPP_ADDR_PWM1) begin
				next_rdata = pwm_hold[1];
			end else if (ADDR == `TPP_ADDR_TCMP_LO) begin
				next_rdata = tcmp_lo;
			end else if (ADDR == `TPP_ADDR_TCMP_HI) begin
				next_rdata = tcmp_hi;
			end else if (ADDR == `TPP_ADDR_CNT0) begin
				next_rdata = cnt[0];
			end else if (ADDR == `TPP_ADDR_CNT1) begin
				next_rdata = cnt[1];
			end else if (ADDR == `TPP_ADDR_CFG) begin
				next_rdata[`TPP_CFG_TAPSEL] = tap_sel;
				next_rdata[`TPP_CFG_FLOP0] = flop[0];
				next_rdata[`TPP_CFG_FLOP1] = flop[1];
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN)
			rdata_q <= `TPP_RDATA_IDLE;
		else
			rdata_q <= next_rdata;
	end

	assign RDATA = rdata_q;
	assign PWM_OUT_PIN = ~flop;
	assign TIMER_MATCH_IRQ = irq;

endmodule

// ### verification/tpp_core_sva.sv
// Checker for tpp_core: read data idling, pulse width, PWM pin behaviour.
// Assumes it is bound to tpp_core and sees only its ports.
`timescale 1ns/1ps
`include "tpp_cfg.svh"
module tpp_core_sva #(
	parameter int DIV_W = `TPP_TAP_SLOW
) (
	input wire logic SYS_CLK, // Clock
	input wire logic RSTN, // Reset, active low
	input wire logic [`TPP_ADDR_W-1:0] ADDR, // Address
	input wire logic [`TPP_DATA_W-1:0] WDATA, // Write data
	input wire logic WR, // Write strobe
	input wire logic RD, // Read strobe
	input wire logic [`TPP_DATA_W-1:0] RDATA, // Read data
	input wire logic LF_CLK, // Slow clock pin
	input wire logic [1:0] PWM_OUT_PIN, // PWM pins
	input wire logic [1:0] TIMER_MATCH_IRQ // Match pulses
);
	import tpp_pkg::*;
	logic [1:0] run, next_run, ctrl_wr;
	logic t16, next_t16;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);
	assign ctrl_wr = {WR && ADDR == 4'h1, WR && ADDR == 4'h0};
	// Mirror of run bits and 16-bit mode
	always_comb begin
		next_run = run;
		next_t16 = t16;
		if (WR && ADDR < 4'h2) begin
			next_run[ADDR[0]] = WDATA[3];
			if (ADDR[0]) next_t16 = WDATA[2:0] == TPP_MODE_TMR16;
		end
	end
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			run <= 2'b00;
			t16 <= 1'b0;
		end else begin
			run <= next_run;
			t16 <= next_t16;
		end
	end
	property p_rd_idle;
		!$past(RD) |-> RDATA == `TPP_RDATA_IDLE;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not idle");
	property p_rd_unmapped;
		RD && ADDR > `TPP_ADDR_CFG |=> RDATA == `TPP_RDATA_IDLE;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped)
		else $error("unmapped read not zero");
	for (genvar i = 0; i < 2; i++) begin : g_ch
		sequence s_load;
			ctrl_wr[i] && !WDATA[3] && !run[i];
		endsequence
		property p_irq_pulse;
			TIMER_MATCH_IRQ[i] |=> !TIMER_MATCH_IRQ[i];
		endproperty
		a_irq_pulse: assert property (p_irq_pulse)
			else $error("match pulse too long");
		property p_wrap_flip;
			$rose(TIMER_MATCH_IRQ[i]) && !t16 |-> $changed(PWM_OUT_PIN[i]);
		endproperty
		a_wrap_flip: assert property (p_wrap_flip)
			else $error("pin did not flip on wrap");
		property p_hold;
			!$past(run[i]) && !$past(ctrl_wr[i]) |-> $stable(PWM_OUT_PIN[i]);
		endproperty
		a_hold: assert property (p_hold)
			else $error("stopped pin moved");
		property p_load;
			s_load |=> PWM_OUT_PIN[i] == !$past(WDATA[7]);
		endproperty
		a_load: assert property (p_load)
			else $error("init bit not loaded");
	end
endmodule

bind tpp_core tpp_core_sva #(.DIV_W(DIV_W)) tpp_core_sva_i (.SYS_CLK(SYS_CLK),
	.RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
	.RDATA(RDATA), .LF_CLK(LF_CLK), .PWM_OUT_PIN(PWM_OUT_PIN),
	.TIMER_MATCH_IRQ(TIMER_MATCH_IRQ));

// ### verification/tpp_core_tb_top.sv
// Bench for tpp_core: PWM wave, compare staging, taps, 16-bit timer.
// Assumes the checker binds itself to tpp_core.
`timescale 1ns/1ps
`include "tpp_cfg.svh"
module tpp_core_tb_top;
	import tpp_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic lf = 1'b0;
	logic [7:0] rdata;
	logic [1:0] pin;
	logic [1:0] irq;
	logic lvl;
	int mismatches = 0;
	int samples_checked = 0;
	int lf_n = 0;
	int a, b, n;
	int codes[4] = '{6, 5, 4, 3};

	tpp_core tpp_core_i (.SYS_CLK(clk), .RSTN(rstn), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .LF_CLK(lf),
		.PWM_OUT_PIN(pin), .TIMER_MATCH_IRQ(irq));

	initial begin
		forever #25 clk = ~clk;
	end
	// Slow clock pin: one rising edge every 16 cycles
	always @(posedge clk) begin
		lf_n <= lf_n + 1;
		lf <= lf_n[3];
	end

	function automatic int div_of(input int code);
		case (code)
			0: return 1 << `TPP_TAP_SLOW;
			1: return 1 << `TPP_TAP_MID;
			2: return 1 << `TPP_TAP_FAST;
			3: return 1 << `TPP_TAP_FASTER;
			4: return 16;
			5: return 1 << `TPP_TAP_HALF;
			default: return 1;
		endcase
	endfunction

	task automatic chk_reg(input string w, input logic [7:0] e,
		input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic chk_time(input string w, input int e, input int g);
		samples_checked++;
		if (g != e) begin
			mismatches++;
			$display("Error %s expected %0d seen %0d", w, e, g);
		end
	endtask
	task automatic wr_reg(input int ad, input int d);
		addr <= ad[3:0];
		wdata <= d[7:0];
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_reg(input int ad, input int e, input string w);
		addr <= ad[3:0];
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		chk_reg(w, e[7:0], rdata);
	endtask
	task automatic gap(input int i, output int c);
		c = 0;
		do begin
			@(posedge clk);
			c++;
		end while (irq[i] !== 1'b1 && c < 20000);
	endtask
	task automatic flip(input int i, output int c);
		logic v;
		v = pin[i];
		c = 0;
		do begin
			@(posedge clk);
			c++;
		end while (pin[i] === v && c < 20000);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		// About twice the expected run length
		repeat (60000) @(posedge clk);
		mismatches++;
		stop_test;
	end

	initial begin
		void'($urandom(32'h9b59));
		repeat (4) @(posedge clk);
		chk_reg("reset pins", 8'h03, {6'h00, pin});
		rstn <= 1'b1;
		wr_reg(6, 8'hFF);
		wr_reg(7, 8'hFF);
		wr_reg(15, 8'hFF);
		for (int k = 0; k < 16; k++) begin
			rd_reg(k, 0, "reset read");
		end
		for (int i = 0; i < 2; i++) begin
			a = 8 + $urandom % 240;
			b = 8 + $urandom % 240;
			wr_reg(`TPP_ADDR_PWM0 + i, a);
			rd_reg(`TPP_ADDR_PWM0 + i, a, "compare");
			wr_reg(i, {i[0], 7'h03});
			chk_reg("init pin", {7'h00, !i[0]}, {7'h00, pin[i]});
			wr_reg(i, {i[0], 7'h6B});
			gap(i, n);
			gap(i, n);
			chk_time("period", 256, n);
			chk_reg("wrap pin", {7'h00, !i[0]}, {7'h00, pin[i]});
			flip(i, n);
			chk_time("match", a, n);
			gap(i, n);
			chk_time("rest", 256 - a, n);
			wr_reg(`TPP_ADDR_PWM0 + i, b);
			flip(i, n);
			chk_time("old match", a - 2, n);
			rd_reg(`TPP_ADDR_PWM0 + i, b, "staged");
			gap(i, n);
			flip(i, n);
			chk_time("new match", b, n);
			wr_reg(i, {i[0], 7'h63});
			lvl = pin[i];
			repeat (300) @(posedge clk);
			chk_reg("held", {7'h00, lvl}, {7'h00, pin[i]});
			wr_reg(i, 8'h63);
			chk_reg("forced", 8'h01, {7'h00, pin[i]});
			wr_reg(i, 8'hE3);
			chk_reg("forced", 8'h00, {7'h00, pin[i]});
		end
		foreach (codes[k]) begin
			wr_reg(0, {1'b0, codes[k][2:0], 4'hB});
			gap(0, n);
			gap(0, n);
			chk_time("tap period", 256 * div_of(codes[k]), n);
		end
		wr_reg(0, 8'h03);
		wr_reg(`TPP_ADDR_TCMP_LO, 2);
		wr_reg(`TPP_ADDR_TCMP_HI, 0);
		for (int c = 0; c < 4; c++) begin
			wr_reg(0, {1'b0, c[2:0], 4'h0});
			wr_reg(1, 8'h0C);
			gap(1, n);
			gap(1, n);
			chk_time("interval", 2 * div_of(c), n);
			wr_reg(1, 8'h04);
		end
		wr_reg(`TPP_ADDR_TCMP_LO, 2);
		wr_reg(`TPP_ADDR_TCMP_HI, 1);
		wr_reg(1, 8'h0C);
		gap(1, n);
		gap(1, n);
		chk_time("cascade", 258 * div_of(3), n);
		stop_test;
	end
endmodule
